// >>> core/shs_pkg.sv
package shs_pkg;

  // APB register byte addresses
  localparam logic [11:0] ADDR_OPMODE   = 12'h000;
  localparam logic [11:0] ADDR_INTTIME  = 12'h004;
  localparam logic [11:0] ADDR_EXPROWS  = 12'h008;
  localparam logic [11:0] ADDR_UPLOAD   = 12'h00C;
  localparam logic [11:0] ADDR_STATUS   = 12'h010;

  // Operation-mode field positions
  localparam int OM_SEQ_EN  = 0;
  localparam int OM_ROLLING = 1;
  localparam int OM_TRIG    = 4;
  localparam int OM_SLAVE   = 5;
  localparam int OM_SUBSAMP = 7;
  localparam int OM_BINNING = 8;
  localparam logic [31:0] OM_MASK = 32'h0000_01B3;

  // Upload register: bits 8:0 address, bits 31:16 data
  localparam int UP_ADDR_LSB = 0;
  localparam int UP_DATA_LSB = 16;

  // Configuration space addresses used by the state flow
  localparam logic [8:0] CFG_LIMIT_SB1 = 9'h028;
  localparam logic [8:0] CFG_CLKMGT    = 9'h020;
  localparam logic [8:0] CFG_LOGIC_EN  = 9'h022;
  localparam logic [8:0] CFG_BIAS      = 9'h040;
  localparam logic [8:0] CFG_LVDS      = 9'h070;
  localparam logic [8:0] CFG_SEQ_LAST  = 9'h1C0;
  localparam logic [15:0] CLK_ANALOG_BIT = 16'h0001;

  // Array geometry and counter defaults
  localparam int ROW_W = 13;
  localparam logic [12:0] ROWS_LAST   = 13'h13FF;
  localparam logic [12:0] OVERHEAD_CY = 13'h0010;
  localparam logic [12:0] ROW_CY      = 13'h0004;
  localparam logic [31:0] INTTIME_RST = 32'h0000_0100;
  localparam logic [12:0] EXPROWS_RST = 13'h0040;

  // Minimum wait after hard reset before the first upload
  localparam int WAKE_NS = 10000;
  localparam int CLK_NS  = 40;
  localparam int WAKE_CY = (WAKE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum { PS_OFF, PS_SB1, PS_SBI, PS_SB2, PS_IDLE, PS_RUN } shs_pwr_e;
  typedef enum { FS_IDLE, FS_INTEG, FS_OVH, FS_READ } shs_frm_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } shs_apb_req_s;

  typedef struct packed {
    logic        pixReset;
    logic        integrating;
    logic        overhead;
    logic        reading;
    logic [12:0] readRow;
    logic [12:0] resetRow;
  } shs_core_s;

endpackage

// >>> core/shs_sequencer.sv
// Summary of operation
// - Pipelined slave ignores integration time, starts on trigger
// - Pipelined slave trigger fall samples, begins readout
// - Triggered mode reads one image, then idles
// - Triggered integration may overlap ongoing readout
// - Triggered master rising edge starts timed integration
// - Timer expiry enters overhead, then line readout
// - Master falling edge ignored; each rise outside integration starts a new frame
// - Triggered slave rise integrates, fall overhead/readout
// - Slave trigger reassertion starts a new frame
// - Rolling mode keeps reset and read row pointers
// - Pointer distance sets equal row exposure
// - Exposure changes apply at frame start, no break
// - Six power states plus flow actions
// - First standby accepts only addresses below 40
// - Second standby: all registers, other blocks disabled
// - Intermediate standby until reserved uploads done
// - Idle runs clocks; sequencer enable starts running
// - Mode reconfiguration keeps the power state
// - Mode bits: 1 rolling, 4 triggered
// - Bit 5 selects slave, resets to 0
// - Bit 0 enables sequencer, starts grabbing
module shs_sequencer
  import shs_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External trigger
  input  wire logic        trigIn,
  // Image core control
  output shs_core_s        core,
  output logic [2:0]       pwrState,
  output logic             blocksEn
);

  // Reset release through two flops
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  wire logic rstN = rstSync_r;

  shs_apb_req_s req;
  assign req = '{psel, penable, pwrite, paddr, pwdata};

  // Register and flow state
  logic [31:0] opMode_r, opMode_nxt;
  logic [31:0] intTime_r, intTime_nxt;
  logic [12:0] expRows_r, expRows_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        accWait_r, accWait_nxt;
  logic        clkMgt_r, clkMgt_nxt;
  logic        logicEn_r, logicEn_nxt;
  logic        analogEn_r, analogEn_nxt;
  logic        seqCfg_r, seqCfg_nxt;
  logic [11:0] wake_r, wake_nxt;
  shs_pwr_e    pwr_r, pwr_nxt;

  // Trigger synchroniser and edge detect
  logic trigMeta_r, trigSync_r, trigOld_r;
  logic trigRise, trigFall;

  // Frame sequencer state
  shs_frm_e    frm_r, frm_nxt;
  logic [31:0] intCnt_r, intCnt_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic [12:0] readRow_r, readRow_nxt;
  logic [12:0] rstRow_r, rstRow_nxt;
  logic [12:0] expLive_r, expLive_nxt;
  logic        integ_r, integ_nxt;
  logic        pendRd_r, pendRd_nxt;

  function automatic logic [31:0] reg_word(input logic [11:0] a);
    case (a)
      ADDR_OPMODE:  reg_word = opMode_r;
      ADDR_INTTIME: reg_word = intTime_r;
      ADDR_EXPROWS: reg_word = {19'h0, expRows_r};
      ADDR_STATUS:  reg_word = {24'h0, integ_r, 2'(frm_r), 2'h0,
                                3'(pwr_r)};
      default:      reg_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_OPMODE) || (a == ADDR_INTTIME) ||
                (a == ADDR_EXPROWS) || (a == ADDR_UPLOAD) ||
                (a == ADDR_STATUS);
  endfunction

  // One wait state so registered read data stands when pready is high
  wire logic acc  = req.psel && req.penable;
  wire logic frst = acc && !accWait_r;
  wire logic wr   = acc && accWait_r && req.pwrite;
  wire logic [8:0]  upAddr = req.pwdata[UP_ADDR_LSB +: 9];
  wire logic [15:0] upData = req.pwdata[UP_DATA_LSB +: 16];
  wire logic upWr = wr && (req.paddr == ADDR_UPLOAD);
  // Mode and time writes land from second standby upward
  wire logic cfgOk = (pwr_r == PS_SB2) || (pwr_r == PS_IDLE) ||
                     (pwr_r == PS_RUN);
  wire logic upOk = (wake_r == 12'(WAKE_CY)) &&
                    ((pwr_r != PS_SB1) || (upAddr < CFG_LIMIT_SB1));

  // Register file and power flow next state
  always_comb
  begin
    opMode_nxt   = opMode_r;
    intTime_nxt  = intTime_r;
    expRows_nxt  = expRows_r;
    clkMgt_nxt   = clkMgt_r;
    logicEn_nxt  = logicEn_r;
    analogEn_nxt = analogEn_r;
    seqCfg_nxt   = seqCfg_r;
    pwr_nxt      = pwr_r;
    prdata_nxt   = prdata_r;
    pslverr_nxt  = 1'b0;
    accWait_nxt  = frst;
    wake_nxt     = (wake_r == 12'(WAKE_CY)) ? wake_r : wake_r + 12'h001;
    if (frst)
    begin
      prdata_nxt  = req.pwrite ? prdata_r : reg_word(req.paddr);
      pslverr_nxt = !is_mapped(req.paddr) ||
                    (req.pwrite && req.paddr == ADDR_UPLOAD && !upOk) ||
                    (req.pwrite && req.paddr == ADDR_STATUS);
    end
    if (wr && cfgOk)
    begin
      // Only mode fields are held; other bits read zero
      if (req.paddr == ADDR_OPMODE)
        opMode_nxt = req.pwdata & OM_MASK;
      if (req.paddr == ADDR_INTTIME)
        intTime_nxt = req.pwdata;
      if (req.paddr == ADDR_EXPROWS)
        expRows_nxt = req.pwdata[12:0];
    end
    if (upWr && !pslverr_r)
    begin
      // Upload steps decode into block enables
      if (upAddr == CFG_CLKMGT)
      begin
        clkMgt_nxt   = 1'b1;
        analogEn_nxt = upData[0] & CLK_ANALOG_BIT[0];
      end
      if (upAddr == CFG_LOGIC_EN)
        logicEn_nxt = upData[0] & clkMgt_r;
      if (upAddr == CFG_SEQ_LAST)
        seqCfg_nxt = 1'b1;
      if (upAddr == CFG_LVDS)
        analogEn_nxt = analogEn_r & (upData != 16'h0000);
    end
    // State flow: mode changes alter state only through the sequencer enable bit
    case (pwr_r)
      PS_OFF:  pwr_nxt = PS_SB1;
      PS_SB1:  if (logicEn_r) pwr_nxt = PS_SBI;
      PS_SBI:  if (seqCfg_r) pwr_nxt = PS_SB2;
      PS_SB2:  if (analogEn_r) pwr_nxt = PS_IDLE;
      PS_IDLE:
      begin
        if (!analogEn_r) pwr_nxt = PS_SB2;
        else if (opMode_r[OM_SEQ_EN]) pwr_nxt = PS_RUN;
      end
      PS_RUN:  if (!opMode_r[OM_SEQ_EN]) pwr_nxt = PS_IDLE;
      default: pwr_nxt = PS_SB1;
    endcase
    if (!logicEn_r && pwr_r != PS_OFF) pwr_nxt = PS_SB1;
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      opMode_r   <= 32'h0000_0000;
      intTime_r  <= INTTIME_RST;
      expRows_r  <= EXPROWS_RST;
      prdata_r   <= 32'h0000_0000;
      pslverr_r  <= 1'b0;
      accWait_r  <= 1'b0;
      clkMgt_r   <= 1'b0;
      logicEn_r  <= 1'b0;
      analogEn_r <= 1'b0;
      seqCfg_r   <= 1'b0;
      wake_r     <= 12'h000;
      pwr_r      <= PS_OFF;
    end
    else
    begin
      opMode_r   <= opMode_nxt;
      intTime_r  <= intTime_nxt;
      expRows_r  <= expRows_nxt;
      prdata_r   <= prdata_nxt;
      pslverr_r  <= pslverr_nxt;
      accWait_r  <= accWait_nxt;
      clkMgt_r   <= clkMgt_nxt;
      logicEn_r  <= logicEn_nxt;
      analogEn_r <= analogEn_nxt;
      seqCfg_r   <= seqCfg_nxt;
      wake_r     <= wake_nxt;
      pwr_r      <= pwr_nxt;
    end
  end

  // Trigger synchroniser; first flop feeds only the second
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      trigMeta_r <= 1'b0;
      trigSync_r <= 1'b0;
      trigOld_r  <= 1'b0;
    end
    else
    begin
      trigMeta_r <= trigIn;
      trigSync_r <= trigMeta_r;
      trigOld_r  <= trigSync_r;
    end
  end
  assign trigRise = trigSync_r && !trigOld_r;
  assign trigFall = !trigSync_r && trigOld_r;

  wire logic running = (pwr_r == PS_RUN);
  wire logic rolling = opMode_r[OM_ROLLING];
  wire logic trigMd  = opMode_r[OM_TRIG];
  wire logic slave   = opMode_r[OM_SLAVE];

  // Frame sequencer: integration runs beside readout
  always_comb
  begin
    frm_nxt     = frm_r;
    intCnt_nxt  = intCnt_r;
    cnt_nxt     = cnt_r;
    readRow_nxt = readRow_r;
    rstRow_nxt  = rstRow_r;
    expLive_nxt = expLive_r;
    integ_nxt   = integ_r;
    pendRd_nxt  = pendRd_r;
    if (!running)
    begin
      frm_nxt    = FS_IDLE;
      integ_nxt  = 1'b0;
      pendRd_nxt = 1'b0;
      readRow_nxt = 13'h0000;
      rstRow_nxt  = expRows_r; // Reset row leads from the start
    end
    else if (rolling)
    begin
      // Reset pointer leads read pointer by exposure rows
      integ_nxt = 1'b0;
      frm_nxt   = FS_READ;
      cnt_nxt   = (cnt_r == ROW_CY) ? 13'h0000 : cnt_r + 13'h0001;
      if (cnt_r == ROW_CY)
      begin
        readRow_nxt = (readRow_r == ROWS_LAST) ? 13'h0000
                                               : readRow_r + 13'h0001;
        rstRow_nxt  = (rstRow_r == ROWS_LAST) ? 13'h0000
                                              : rstRow_r + 13'h0001;
        // New exposure taken at frame start only
        if (readRow_r == ROWS_LAST)
        begin
          expLive_nxt = expRows_r;
          rstRow_nxt  = expRows_r;
        end
      end
    end
    else
    begin
      // Integration side (global shutter)
      if (!integ_r)
      begin
        if (!trigMd && !slave && frm_r == FS_IDLE)
          integ_nxt = 1'b1; // Pipelined master free runs
        if (slave && trigRise)
          integ_nxt = 1'b1;
        if (trigMd && !slave && trigRise)
          integ_nxt = 1'b1;
        intCnt_nxt = 32'h0000_0001; // First integrating cycle counts
      end
      else
      begin
        intCnt_nxt = intCnt_r + 32'h0000_0001;
        // Slave ends on trigger fall; master on timer
        if ((slave && trigFall) ||
            (!slave && intCnt_r >= intTime_r))
        begin
          integ_nxt  = 1'b0;
          pendRd_nxt = 1'b1;
        end
      end
      // Readout side; may overlap next integration
      case (frm_r)
        FS_IDLE, FS_INTEG:
        begin
          frm_nxt = integ_r ? FS_INTEG : FS_IDLE;
          if (pendRd_r)
          begin
            frm_nxt    = FS_OVH;
            pendRd_nxt = 1'b0;
            cnt_nxt    = 13'h0000;
          end
        end
        FS_OVH:
        begin
          cnt_nxt = cnt_r + 13'h0001;
          if (cnt_r == OVERHEAD_CY)
          begin
            frm_nxt     = FS_READ;
            cnt_nxt     = 13'h0000;
            readRow_nxt = 13'h0000;
          end
        end
        FS_READ:
        begin
          cnt_nxt = (cnt_r == ROW_CY) ? 13'h0000 : cnt_r + 13'h0001;
          if (cnt_r == ROW_CY)
          begin
            readRow_nxt = readRow_r + 13'h0001;
            if (readRow_r == ROWS_LAST)
            begin
              frm_nxt = integ_r ? FS_INTEG : FS_IDLE;
              if (pendRd_r)
              begin
                frm_nxt    = FS_OVH;
                pendRd_nxt = integ_r && !integ_nxt; // Set wins
              end
            end
          end
        end
        default: frm_nxt = FS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      frm_r     <= FS_IDLE;
      intCnt_r  <= 32'h0000_0000;
      cnt_r     <= 13'h0000;
      readRow_r <= 13'h0000;
      rstRow_r  <= 13'h0000;
      expLive_r <= EXPROWS_RST;
      integ_r   <= 1'b0;
      pendRd_r  <= 1'b0;
    end
    else
    begin
      frm_r     <= frm_nxt;
      intCnt_r  <= intCnt_nxt;
      cnt_r     <= cnt_nxt;
      readRow_r <= readRow_nxt;
      rstRow_r  <= rstRow_nxt;
      expLive_r <= expLive_nxt;
      integ_r   <= integ_nxt;
      pendRd_r  <= pendRd_nxt;
    end
  end

  // Outputs
  assign prdata  = prdata_r;
  assign pready  = accWait_r;
  assign pslverr = pslverr_r && psel && penable;
  assign pwrState = 3'(pwr_r);
  assign blocksEn = (pwr_r == PS_IDLE) || running; // Follows state
  assign core.pixReset    = !integ_r && !rolling;
  assign core.integrating = integ_r;
  assign core.overhead    = (frm_r == FS_OVH);
  assign core.reading     = (frm_r == FS_READ);
  assign core.readRow     = readRow_r;
  assign core.resetRow    = rstRow_r;

endmodule

// >>> testbench/shs_seq_properties.sv
module shs_seq_properties
  import shs_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // APB side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        pready,
  // Trigger and image core state
  input wire logic        trigIn,
  input wire shs_core_s   core,
  input wire logic [2:0]  pwrState,
  input wire logic        blocksEn
);
  logic [31:0] modeR;
  logic [31:0] modeNxt;

  // Mirror of the mode register; writes below standby 2 do not land
  always_comb
  begin
    modeNxt = modeR;
    if (psel && penable && pready && pwrite && paddr == ADDR_OPMODE &&
        pwrState >= 3'h3)
      modeNxt = pwdata & OM_MASK;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      modeR <= 32'h0000_0000;
    else
      modeR <= modeNxt;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence wr_s(logic [11:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  sequence up_s(logic [8:0] a);
    wr_s(ADDR_UPLOAD) ##0 pwdata[8:0] == a;
  endsequence

  // Global shutter only; the synchroniser costs a few cycles of latency
  sequence glob_run_s;
    pwrState == 3'h5 && !modeR[OM_ROLLING];
  endsequence

  state_range_a: assert property (pwrState <= 3'h5)
    else $error("power state out of range");
  legal_step_a: assert property (pwrState != $past(pwrState) |->
    {$past(pwrState), pwrState} inside
    {6'h01, 6'h0A, 6'h13, 6'h1C, 6'h25, 6'h2C, 6'h23})
    else $error("illegal power state step");
  sb1_refuse_a: assert property ((psel && penable && !pready) ##0
    (pwrite && paddr == ADDR_UPLOAD && pwrState == 3'h1 &&
    pwdata[8:0] >= CFG_LIMIT_SB1) |=> pslverr)
    else $error("high upload taken in standby 1");
  sb2_entry_a: assert property (up_s(CFG_SEQ_LAST) ##0
    pwrState == 3'h2 |-> ##[1:2] pwrState == 3'h3)
    else $error("last reserved upload did not reach standby 2");
  seq_start_a: assert property (wr_s(ADDR_OPMODE) ##0
    (pwdata[OM_SEQ_EN] && pwrState == 3'h4) |-> ##[1:2] pwrState == 3'h5)
    else $error("sequencer enable did not start running");
  mode_keep_a: assert property (wr_s(ADDR_OPMODE) ##0
    (!pwdata[OM_SEQ_EN] && pwrState inside {3'h3, 3'h4}) |=>
    $stable(pwrState))
    else $error("mode change moved the power state");
  blocks_en_a: assert property (pwrState >= 3'h3 |->
    blocksEn == (pwrState != 3'h3))
    else $error("block enable does not follow power state");
  slave_start_a: assert property (glob_run_s ##0
    (modeR[OM_SLAVE] && $rose(trigIn)) |-> ##[1:5] core.integrating)
    else $error("slave trigger did not start integration");
  slave_stop_a: assert property (glob_run_s ##0
    (modeR[OM_SLAVE] && $fell(trigIn)) |-> ##[1:5] !core.integrating)
    else $error("slave trigger fall did not end integration");
  master_start_a: assert property (glob_run_s ##0
    (modeR[OM_TRIG] && !modeR[OM_SLAVE] && $rose(trigIn) &&
    !core.integrating) |-> ##[1:5] core.integrating)
    else $error("master trigger did not start integration");
endmodule

bind shs_sequencer shs_seq_properties u_shs_seq_properties (
  .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .pready,
  .trigIn, .core, .pwrState, .blocksEn
);

// >>> testbench/shs_ctrl_model.sv
module shs_ctrl_model
(
  // Clock
  input wire logic        mclk,
  // Requests from the bench
  input wire logic        go,
  input wire logic [15:0] highCy,
  // Trigger pin toward the sensor
  output logic            trigIn
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] cntR;

  initial
  begin
    trigIn = 1'b0;
    cntR   = 16'h0000;
  end

  // Pin stays high highCy cycles, then returns low, so every request is
  // a fresh rising edge; timing a request into a readout makes overlap
  always @(posedge mclk)
  begin
    if (go)
    begin
      trigIn <= 1'b1;
      cntR   <= highCy;
    end
    else if (cntR != 16'h0000)
    begin
      trigIn <= (cntR != 16'h0001);
      cntR   <= cntR - 16'h0001;
    end
  end
endmodule

// >>> testbench/shs_sequencer_tb.sv
module shs_sequencer_tb
  import shs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trigIn;
  shs_core_s   core;
  logic [2:0]  pwrState;
  logic        blocksEn;
  logic        go;
  logic [15:0] highCy;
  logic [31:0] rdVal;
  logic        errSeen;
  int          numErrors;
  int          nChecks;
  int          cyc;
  int          n;

  shs_sequencer u_shs_sequencer (.mclk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trigIn, .core,
    .pwrState, .blocksEn);
  shs_ctrl_model u_shs_ctrl_model (.mclk, .go, .highCy, .trigIn);

  // 25 MHz clock
  always #20 mclk = ~mclk;

  // Hang guard, well above two full frame readouts
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      numErrors++;
      endOfTest();
    end
  end

  task endOfTest;
    if (numErrors == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("wrong value at %0t ns: got %h, want %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high; data and error taken at that
  // edge; one idle edge follows so no signal is set twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rdVal   = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task up(input logic [8:0] a, input logic [15:0] d);
    apb(1'b1, ADDR_UPLOAD, {d, 7'h00, a});
  endtask

  task rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdVal & m, e);
  endtask

  task pulse(input logic [15:0] h);
    highCy <= h;
    go     <= 1'b1;
    @(posedge mclk);
    go     <= 1'b0;
  endtask

  // Counts integrating cycles; ends one falling edge after the end, once
  // the pending readout has had a cycle to take effect
  task measure;
    n = 0;
    while (core.integrating !== 1'b1)
      @(negedge mclk);
    while (core.integrating === 1'b1)
    begin
      n++;
      @(negedge mclk);
    end
    @(negedge mclk);
  endtask

  task idleWait;
    while ((core.reading || core.overhead || core.integrating) !== 1'b0)
      @(negedge mclk);
    @(posedge mclk);
  endtask

  task tSb1;
    rdChk(ADDR_STATUS, 32'h7, 32'h1);
    wr(ADDR_OPMODE, 32'h0000_0002);
    rdChk(ADDR_OPMODE, 32'hFFFF_FFFF, 32'h0);
    apb(1'b1, ADDR_UPLOAD, {16'h0001, 7'h00, CFG_LIMIT_SB1});
    cmp({31'h0, errSeen}, 32'h1);
    up(CFG_CLKMGT, 16'h2002);
    up(CFG_LOGIC_EN, 16'h0001);
    rdChk(ADDR_STATUS, 32'h7, 32'h2);
  endtask

  task tSb2;
    up(CFG_SEQ_LAST, 16'h0BC3);
    rdChk(ADDR_STATUS, 32'h7, 32'h3);
    wr(ADDR_INTTIME, 32'h0000_0014);
    rdChk(ADDR_INTTIME, 32'hFFFF_FFFF, 32'h14);
    apb(1'b1, ADDR_STATUS, 32'h0000_0000);
    cmp({31'h0, errSeen}, 32'h1);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    cmp({31'h0, errSeen}, 32'h1);
    up(CFG_CLKMGT, 16'h2003);
    rdChk(ADDR_STATUS, 32'h7, 32'h4);
    cmp({31'h0, blocksEn}, 32'h1);
  endtask

  // Short pulse, then a long one into the readout: both integrations last 20 cycles
  task tMaster;
    wr(ADDR_OPMODE, 32'h0000_0010);
    rdChk(ADDR_STATUS, 32'h7, 32'h4);
    wr(ADDR_OPMODE, 32'h0000_0011);
    rdChk(ADDR_STATUS, 32'h7, 32'h5);
    cmp({31'h0, core.pixReset}, 32'h1);
    pulse(16'h0002);
    measure();
    cmp(n, 32'd20);
    cmp({31'h0, core.overhead}, 32'h1);
    while (core.reading !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
    pulse(16'h003C);
    measure();
    cmp(n, 32'd20);
    cmp({31'h0, core.reading}, 32'h1);
    @(posedge mclk);
    idleWait();
    repeat (8) @(posedge mclk);
    idleWait();
    rdChk(ADDR_STATUS, 32'hE0, 32'h0);
  endtask

  // Triggered slave, then pipelined slave; the pin sets integration
  task tSlave;
    logic [31:0] m;
    for (int i = 0; i < 2; i++)
    begin
      m = (i == 0) ? 32'h0000_0030 : 32'h0000_0020;
      wr(ADDR_OPMODE, m);
      wr(ADDR_OPMODE, m | 32'h1);
      pulse(16'h001E);
      measure();
      cmp(n, 32'd30);
      cmp({31'h0, core.overhead | core.reading}, 32'h1);
      @(posedge mclk);
      pulse(16'h000A);
      measure();
      cmp(n, 32'd10);
      @(posedge mclk);
    end
  endtask

  task tRoll;
    wr(ADDR_OPMODE, 32'h0000_0002);
    wr(ADDR_OPMODE, 32'h0000_0003);
    repeat (100) @(negedge mclk);
    cmp({31'h0, core.resetRow != core.readRow}, 32'h1);
    @(posedge mclk);
    wr(ADDR_EXPROWS, 32'h0000_0020);
    rdChk(ADDR_STATUS, 32'h7, 32'h5);
    wr(ADDR_OPMODE, 32'h0000_0002);
    up(CFG_LVDS, 16'h0000);
    rdChk(ADDR_STATUS, 32'h7, 32'h3);
    cmp({31'h0, blocksEn}, 32'h0);
  endtask

  // Clock runs before reset release; uploads wait out the wake time
  initial
  begin
    mclk      = 1'b0;
    nrst      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    go        = 1'b0;
    highCy    = 16'h0000;
    errSeen   = 1'b0;
    numErrors = 0;
    nChecks   = 0;
    cyc       = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (260) @(posedge mclk);
    tSb1();
    tSb2();
    tMaster();
    tSlave();
    tRoll();
    endOfTest();
  end
endmodule
